/* File: hw/tmr_pkg.sv */
/*
  Constants shared by the comparator-count / capture timer slice:
  register offsets, field positions, reset values and encodings.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
// Operation
// [RQ1] Comparator mode counts comparator edges, not clocks.
// [RQ2] Polarity bit picks rising or falling comparator edge.
// [RQ3] Comparator mode bypasses the prescaler entirely.
// [RQ4] Comparator reload: interrupt, count to one, continue.
// [RQ5] Enabled output inverts at each comparator reload.
// [RQ6] Polarity bit sets initial output level always.
// [RQ7] Start count only for first pass; then one.
// [RQ8] Software disables, configures, loads, then enables.
// [RQ9] Capture edge: interrupt, count keeps running on.
// [RQ10] Capture event sets the capture interrupt flag.
// [RQ11] Capture mode counts to reload; interrupt, continue.
// [RQ12] Reload interrupt clears the capture interrupt flag.
// [RQ13] Software zeroes capture value; zero means reload.
// [RQ14] Source field: both, capture only, reload only.
// [RQ15] Software sequence for capture mode before enabling.
// [RQ16] Interrupt request pulse lasts one clock period.
// [RQ17] Disabled: output equals polarity; enabled: toggles. Code toggles in comparator mode only, holds in capture.
// [RQ18] Prescaler divides by two to the exponent; resets.
// [RQ19] Disabled timer holds count and raises nothing.
package tmr_pkg;
  // =========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_CAPT   = 8'h0c;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  // =========================================================
  // timer_control_one field positions
  localparam int CTL_EN     = 0;
  localparam int CTL_MODE   = 1;
  localparam int CTL_POL    = 2;
  localparam int CTL_PRE_LO = 3;
  localparam int CTL_PRE_HI = 5;
  localparam int CTL_OUTEN  = 6;
  localparam int CTL_SRC_LO = 8;
  localparam int CTL_SRC_HI = 9;
  localparam int CTL_CAPF   = 16;
  // status and mask bit positions
  localparam int ST_RELOAD  = 0;
  localparam int ST_CAPTURE = 1;
  // =========================================================
  // reset values and fixed counts
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0001;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [15:0] CAPT_RST   = 16'h0000;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [1:0]  STAT_RST   = 2'h0;
  localparam int          PRE_W      = 7;
  // =========================================================
  // enumerations
  typedef enum logic {MODE_CAPTURE, MODE_CMP_COUNT} tmr_mode_t;
  typedef enum logic [1:0] {
    SRC_BOTH, SRC_CAPT_ONLY, SRC_RELOAD_ONLY, SRC_BOTH_ALT
  } int_src_t;
endpackage

/* File: hw/edge_pick.sv */
/*
  Two-flop synchroniser with selectable edge detection.
  Assumes sig_i is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module edge_pick (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin side
  input  wire logic sig_i,
  input  wire logic fall_sel_i,
  // detected edge
  output logic      edge_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // =========================================================
  // synchroniser and history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= sig_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // rising or falling edge as selected
  assign edge_o = fall_sel_i ? (prev_reg & ~sync_reg)
                             : (sync_reg & ~prev_reg);
endmodule

/* File: hw/prescaler.sv */
/*
  Power-of-two prescaler for the system clock.
  Assumes run_i is low whenever the divider must restart.
*/
`timescale 1ns/1ps
module prescaler
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] exp_i,
  // one tick per divided period
  output logic            tick_o
);
  logic [PRE_W-1:0] div_reg;
  logic [PRE_W-1:0] lim;

  // low exp_i bits set: the last count of a period
  assign lim = PRE_W'((8'h01 << exp_i) - 8'h01);

  // =========================================================
  // divider counter, cleared while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      div_reg <= '0; // [RQ18]
    end else if (div_reg == lim) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + PRE_W'(1);
    end
  end

  assign tick_o = run_i && (div_reg == lim);
endmodule

/* File: hw/tmr_slice.sv */
/*
  Timer slice: comparator counter and capture modes with a
  classic Wishbone register port and a level interrupt.
  Assumes a 200 MHz clk_i, synchronous active-high rst_i,
  and pin / comparator inputs asynchronous to clk_i.
*/
`timescale 1ns/1ps
module tmr_slice (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // event sources
  input  wire logic        cmp_out_i,
  input  wire logic        timer_in_i,
  // timer output pin
  output logic             timer_out_o,
  output logic             timer_out_oe_o,
  // interrupts
  output logic             irq_pulse_o,
  output logic             irq_o
);
  import tmr_pkg::*;

  // =========================================================
  // declarations
  logic [15:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [15:0] capt_reg;
  logic [1:0]  stat_reg;
  logic [1:0]  stat_next;
  logic [1:0]  mask_reg;
  logic        capf_reg;
  logic        out_reg;
  logic        oe_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        irq_reg;
  logic        pulse_reg;

  logic        en;
  tmr_mode_t   mode;
  logic        pol;
  int_src_t    src;
  logic        bus_req;
  logic        wr;
  logic [31:0] wmask;
  logic        wr_count;
  logic        cmp_edge;
  logic        cap_edge;
  logic        pre_tick;
  logic        step;
  logic        at_reload;
  logic        ev_reload;
  logic        ev_capture;
  logic        ev_sel;

  assign en   = ctrl_reg[CTL_EN];
  assign mode = tmr_mode_t'(ctrl_reg[CTL_MODE]);
  assign pol  = ctrl_reg[CTL_POL];
  assign src  = int_src_t'(ctrl_reg[CTL_SRC_HI:CTL_SRC_LO]);

  // =========================================================
  // event front ends
  // comparator edge chosen by the polarity bit
  edge_pick u_cmp_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .sig_i      (cmp_out_i),
    .fall_sel_i (pol),
    .edge_o     (cmp_edge)
  ); // [RQ2]

  // capture edge chosen by the same bit
  edge_pick u_cap_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .sig_i      (timer_in_i),
    .fall_sel_i (pol),
    .edge_o     (cap_edge)
  );

  // divider runs only while enabled in capture mode
  prescaler u_pre (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (en && mode == MODE_CAPTURE),
    .exp_i  (ctrl_reg[CTL_PRE_HI:CTL_PRE_LO]),
    .tick_o (pre_tick)
  ); // [RQ18]

  // =========================================================
  // counting events
  // comparator edges step the count directly, no divider
  always_comb begin
    if (mode == MODE_CMP_COUNT) begin
      step = en && cmp_edge; // [RQ1] [RQ3]
    end else begin
      step = en && pre_tick;
    end
  end

  assign at_reload  = (count_reg == reload_reg);
  assign ev_reload  = step && at_reload; // [RQ19]
  assign ev_capture = en && mode == MODE_CAPTURE && cap_edge;

  // source filter for the interrupt request
  always_comb begin
    case (src)
      SRC_CAPT_ONLY:   ev_sel = ev_capture; // [RQ14]
      SRC_RELOAD_ONLY: ev_sel = ev_reload;
      default:         ev_sel = ev_capture || ev_reload;
    endcase
  end

  // =========================================================
  // wishbone decode
  assign bus_req  = cyc_i && stb_i && !ack_reg;
  assign wr       = bus_req && we_i;
  assign wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wr_count = wr && adr_i == OFS_COUNT;

  // merge write data into a 16-bit register under byte enables
  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [31:0] new_v,
    input logic [31:0] msk
  );
    merge16 = (old_v & ~msk[15:0]) | (new_v[15:0] & msk[15:0]);
  endfunction

  // one-cycle acknowledge, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // registered read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      if (adr_i == OFS_CTRL) begin
        rdat_reg <= {15'h0000, capf_reg, ctrl_reg};
      end else if (adr_i == OFS_COUNT) begin
        rdat_reg <= {16'h0000, count_reg};
      end else if (adr_i == OFS_RELOAD) begin
        rdat_reg <= {16'h0000, reload_reg};
      end else if (adr_i == OFS_CAPT) begin
        rdat_reg <= {16'h0000, capt_reg};
      end else if (adr_i == OFS_STAT) begin
        rdat_reg <= {30'h0000_0000, stat_reg};
      end else if (adr_i == OFS_MASK) begin
        rdat_reg <= {30'h0000_0000, mask_reg};
      end else begin
        rdat_reg <= 32'h0000_0000;
      end
    end
  end

  // =========================================================
  // control registers
  // control, reload and mask writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= CTRL_RST;
      reload_reg <= RELOAD_RST;
      mask_reg   <= STAT_RST;
    end else if (wr) begin
      if (adr_i == OFS_CTRL) begin
        ctrl_reg <= merge16(ctrl_reg, dat_i, wmask);
      end else if (adr_i == OFS_RELOAD) begin
        reload_reg <= merge16(reload_reg, dat_i, wmask);
      end else if (adr_i == OFS_MASK && sel_i[0]) begin
        mask_reg <= dat_i[1:0];
      end
    end
  end

  // =========================================================
  // counter
  // software load wins; start value lasts one pass only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= COUNT_RST;
    end else if (wr_count) begin
      count_reg <= merge16(count_reg, dat_i, wmask);
    end else if (ev_reload) begin
      count_reg <= COUNT_ONE; // [RQ4] [RQ7] [RQ11]
    end else if (step) begin
      count_reg <= count_reg + 16'h0001; // [RQ9]
    end
  end

  // =========================================================
  // capture value and capture flag
  // capture beats a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capt_reg <= CAPT_RST;
    end else if (ev_capture) begin
      capt_reg <= count_reg;
    end else if (wr && adr_i == OFS_CAPT) begin
      capt_reg <= merge16(capt_reg, dat_i, wmask);
    end
  end

  // flag marks what caused the latest interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capf_reg <= 1'b0;
    end else if (ev_capture) begin
      capf_reg <= 1'b1; // [RQ10]
    end else if (ev_reload && mode == MODE_CAPTURE) begin
      capf_reg <= 1'b0; // [RQ12]
    end
  end

  // =========================================================
  // timer output
  // follows polarity while disabled, toggles at reload in comparator mode only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= CTRL_RST[CTL_POL];
    end else if (!en) begin
      out_reg <= pol; // [RQ6] [RQ17]
    end else if (ev_reload && mode == MODE_CMP_COUNT) begin
      out_reg <= !out_reg; // [RQ5] [RQ17]
    end
  end

  // pin drive enable from the alternate function bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= ctrl_reg[CTL_OUTEN];
    end
  end

  // =========================================================
  // interrupts
  // sticky status, write one to clear, set wins
  always_comb begin
    stat_next = stat_reg;
    if (wr && adr_i == OFS_STAT && sel_i[0]) begin
      stat_next = stat_reg & ~dat_i[1:0];
    end
    if (ev_reload) begin
      stat_next[ST_RELOAD] = 1'b1;
    end
    if (ev_capture) begin
      stat_next[ST_CAPTURE] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // level request while an unmasked status bit is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  // single-period request to the interrupt controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= ev_sel; // [RQ16]
    end
  end

  // =========================================================
  // outputs
  assign dat_o          = rdat_reg;
  assign ack_o          = ack_reg;
  assign timer_out_o    = out_reg;
  assign timer_out_oe_o = oe_reg;
  assign irq_pulse_o    = pulse_reg;
  assign irq_o          = irq_reg;

  // =========================================================
  // assertions
  sequence s_cmp_wrap;
    en && mode == MODE_CMP_COUNT && cmp_edge && at_reload
      && !wr_count;
  endsequence

  sequence s_cap_wrap;
    en && mode == MODE_CAPTURE && pre_tick && at_reload
      && !cap_edge && !wr_count;
  endsequence

  property p_wrap_to_one;
    @(posedge clk_i) disable iff (rst_i)
      s_cmp_wrap |=> count_reg == COUNT_ONE;
  endproperty

  a_cmp_wrap_one: assert property (p_wrap_to_one) // [RQ4] [RQ7]
    else $error("comparator reload did not restart at one");

  a_cmp_no_edge: assert property ( // [RQ1]
    @(posedge clk_i) disable iff (rst_i)
      en && mode == MODE_CMP_COUNT && !cmp_edge && !wr_count
        |=> count_reg == $past(count_reg))
    else $error("comparator count moved without an edge");

  a_out_toggles: assert property ( // [RQ5]
    @(posedge clk_i) disable iff (rst_i)
      s_cmp_wrap ##1 en |-> out_reg != $past(out_reg))
    else $error("output did not invert at reload");

  a_out_idle_pol: assert property ( // [RQ17]
    @(posedge clk_i) disable iff (rst_i)
      !en |=> out_reg == $past(pol))
    else $error("disabled output differs from polarity");

  a_hold_disabled: assert property ( // [RQ19]
    @(posedge clk_i) disable iff (rst_i)
      !en && !wr_count |=> $stable(count_reg) && !irq_pulse_o)
    else $error("disabled timer moved or interrupted");

  a_capture_value: assert property ( // [RQ9] [RQ10]
    @(posedge clk_i) disable iff (rst_i)
      ev_capture |=> capf_reg && capt_reg == $past(count_reg))
    else $error("capture value or flag wrong");

  property p_cap_clear;
    @(posedge clk_i) disable iff (rst_i)
      s_cap_wrap |=> !capf_reg && count_reg == COUNT_ONE;
  endproperty

  a_reload_clr_flag: assert property (p_cap_clear) // [RQ12]
    else $error("reload left the capture flag set");

  a_pulse_cause: assert property ( // [RQ14] [RQ16]
    @(posedge clk_i) disable iff (rst_i)
      irq_pulse_o == $past(ev_sel)
        && (!irq_pulse_o || $past(src) != SRC_RELOAD_ONLY
            || $past(ev_reload)))
    else $error("interrupt pulse without selected cause");
endmodule

/* File: verif/edge_source.sv */
/*
  Far-side model: analog comparator output and capture input pin.
  Assumes the bench asks for one transition at a time on cmp_go_i or
  cap_go_i, each held for a single clock.
*/
`timescale 1ns/1ps
module edge_source (
  // clock
  input  wire logic clk_i,
  // toggle commands from the bench
  input  wire logic cmp_go_i,
  input  wire logic cap_go_i,
  // lines into the timer
  output logic      cmp_out_o,
  output logic      timer_in_o
);
  logic [1:0] gap_reg;

  // start idle low with no guard time running
  initial begin
    gap_reg    = 2'h0;
    cmp_out_o  = 1'b0;
    timer_in_o = 1'b0;
  end

  // each command flips one line; the guard keeps edges at least four clocks apart
  always @(posedge clk_i) begin
    if (gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end else if (cmp_go_i || cap_go_i) begin
      gap_reg    <= 2'h3;
      cmp_out_o  <= cmp_out_o ^ cmp_go_i;
      timer_in_o <= timer_in_o ^ cap_go_i;
    end
  end
endmodule

/* File: verif/tb_top.sv */
/*
  Self-checking bench for the timer slice: register reset values,
  comparator counter mode, capture mode with every interrupt source
  setting, prescaler rate and a reset in mid-run.
  Assumes the design package and edge_source are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import tmr_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] e;} row_t;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc, stb, we, ack, cmp_out, timer_in;
  logic        t_out, t_oe, irq_pulse, irq, cmp_go, cap_go;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r;
  int          bad_count, checks, cycles, pulses;
  row_t        rows [7] = '{'{OFS_CTRL, 32'h0}, '{OFS_COUNT, 32'h1},
    '{OFS_RELOAD, 32'hffff}, '{OFS_CAPT, 32'h0}, '{OFS_STAT, 32'h0},
    '{OFS_MASK, 32'h0}, '{8'h18, 32'h0}};

  // ==========================================================
  // clock, design, far side
  always #2.5 clk_i = ~clk_i;

  tmr_slice uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .cmp_out_i(cmp_out), .timer_in_i(timer_in), .timer_out_o(t_out),
    .timer_out_oe_o(t_oe), .irq_pulse_o(irq_pulse), .irq_o(irq));

  edge_source far (.clk_i(clk_i), .cmp_go_i(cmp_go), .cap_go_i(cap_go),
    .cmp_out_o(cmp_out), .timer_in_o(timer_in));

  // ==========================================================
  // helpers
  // cycles with the request pulse high; each event passed by the source filter should add exactly one
  always @(posedge clk_i) begin
    if (irq_pulse === 1'b1) pulses <= pulses + 1;
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no ack");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(a, 1'b0, 32'h0, q);
  endtask

  // n full pulses (rise then fall) on the comparator or capture line
  task automatic pulse(input logic c, input int n);
    repeat (2 * n) begin
      @(posedge clk_i);
      cmp_go <= c;
      cap_go <= !c;
      @(posedge clk_i);
      cmp_go <= 1'b0;
      cap_go <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask

  task automatic reset_and_rows;
    logic [31:0] q;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({28'h0, t_out, t_oe, irq, irq_pulse}, 32'h0, "outputs after reset");
    foreach (rows[i]) begin
      rd(rows[i].a, q);
      chk(q, rows[i].e, "reset value");
    end
  endtask

  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q, c, n;
    int          p0;
    {cyc, stb, we, adr, sel, dat_w, cmp_go, cap_go} = '0;
    rst_i = 1'b1;
    reset_and_rows();
    // comparator counter: disabled setup, prescale 7, output on, then enable
    wr(OFS_CTRL, 32'h7a);
    // pin outputs follow the control write one edge later
    @(posedge clk_i);
    chk({31'h0, t_out}, 32'h0, "idle output");
    chk({31'h0, t_oe}, 32'h1, "output drive");
    wr(OFS_COUNT, 32'h3);
    wr(OFS_RELOAD, 32'h5);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h7b);
    p0 = pulses;
    pulse(1'b1, 2);
    rd(OFS_COUNT, q);
    chk(q, 32'h5, "comparator count");
    pulse(1'b1, 1);
    rd(OFS_COUNT, q);
    chk(q, 32'h1, "count after reload");
    chk({31'h0, t_out}, 32'h1, "output toggled");
    chk(pulses - p0, 1, "one request pulse");
    chk({31'h0, irq}, 32'h1, "level interrupt");
    rd(OFS_STAT, q);
    chk(q, 32'h1, "reload status");
    wr(OFS_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "interrupt cleared");
    pulse(1'b1, 5);
    rd(OFS_COUNT, q);
    chk(q, 32'h1, "second pass from one");
    chk({31'h0, t_out}, 32'h0, "output toggled back");
    // disabled: hold count, no events, output follows polarity
    wr(OFS_CTRL, 32'h7e);
    @(posedge clk_i);
    chk({31'h0, t_out}, 32'h1, "polarity level");
    p0 = pulses;
    pulse(1'b1, 1);
    rd(OFS_COUNT, q);
    chk(q, 32'h1, "held while disabled");
    chk(pulses - p0, 0, "no event while disabled");
    // falling edge selected: a rise alone must not count
    wr(OFS_CTRL, 32'h7f);
    @(posedge clk_i);
    cmp_go <= 1'b1;
    @(posedge clk_i);
    cmp_go <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(OFS_COUNT, q);
    chk(q, 32'h1, "rise ignored");
    pulse(1'b1, 0);
    @(posedge clk_i);
    cmp_go <= 1'b1;
    @(posedge clk_i);
    cmp_go <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(OFS_COUNT, q);
    chk(q, 32'h2, "fall counted");
    // capture mode under each interrupt source setting
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'(s) << 8);
      wr(OFS_COUNT, 32'h1);
      wr(OFS_RELOAD, 32'h60);
      wr(OFS_CAPT, 32'h0);
      wr(OFS_STAT, 32'h3);
      wr(OFS_MASK, 32'h3);
      p0 = pulses;
      wr(OFS_CTRL, (32'(s) << 8) | 32'h1);
      pulse(1'b0, 1);
      rd(OFS_CTRL, q);
      chk({31'h0, q[CTL_CAPF]}, 32'h1, "capture flag set");
      rd(OFS_CAPT, c);
      rd(OFS_COUNT, n);
      chk({31'h0, c !== 32'h0}, 32'h1, "value captured");
      chk({31'h0, n > c}, 32'h1, "count runs on");
      rd(OFS_STAT, q);
      chk(q, 32'h2, "capture status");
      repeat (100) @(posedge clk_i);
      rd(OFS_CTRL, q);
      chk({31'h0, q[CTL_CAPF]}, 32'h0, "flag cleared by reload");
      rd(OFS_STAT, q);
      chk(q, 32'h3, "reload status");
      chk(pulses - p0, int'(s != 2) + int'(s != 1), "source filter");
    end
    // prescale exponent 2: one step every four clocks over 43 clocks
    wr(OFS_CTRL, 32'h10);
    wr(OFS_RELOAD, 32'hffff);
    wr(OFS_COUNT, 32'h1);
    wr(OFS_CTRL, 32'h11);
    rd(OFS_COUNT, c);
    repeat (40) @(posedge clk_i);
    rd(OFS_COUNT, n);
    chk({31'h0, (n - c) inside {[32'd10:32'd11]}}, 32'h1, "prescaled rate");
    // reset in mid-run restores everything
    reset_and_rows();
    end_of_test();
  end
endmodule
